// file: logic/fcb_code_store.sv
// Ordered trouble code store, append only, cleared by power removal
`timescale 1ns/1ps
`default_nettype none

module fcb_code_store
    import fcb_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              reset_i,
    input  wire logic              ce_i,
    input  wire logic              wr_i,
    input  wire logic [CODE_W-1:0] wr_code_i,
    input  wire logic [CNT_W-1:0]  rd_idx_i,
    output logic      [CODE_W-1:0] rd_code_o,
    output logic      [CNT_W-1:0]  count_o
);

    // -----------------------------------------------------------------
    // State
    // -----------------------------------------------------------------
    typedef struct packed {
        logic [5:0][CODE_W-1:0] codes;   // Slot array, oldest first
        logic [CNT_W-1:0]       count;   // Slots in use
    } fcb_store_s;

    fcb_store_s q;                       // Registered state
    fcb_store_s n;                       // Next state
    logic       hit;                     // Code already held
    logic       accept;                  // Write takes effect

    // -----------------------------------------------------------------
    // Next state: append unless full or already present
    // -----------------------------------------------------------------
    always_comb begin
        n   = q;
        hit = 1'b0;
        // Repeated detections of one fault keep a single slot
        for (int i = 0; i < 6; i++) begin
            if (CNT_W'(i) < q.count && q.codes[i] == wr_code_i) begin
                hit = 1'b1;
            end
        end
        accept = ce_i && wr_i && !hit && (q.count < MAX_CODES);
        if (accept) begin
            n.codes[q.count] = wr_code_i;
            n.count          = q.count + 3'h1;
        end
    end

    // -----------------------------------------------------------------
    // Registers; only power removal empties the store
    // -----------------------------------------------------------------
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    // Read port, out of range slots read as zero
    assign rd_code_o = (rd_idx_i < q.count) ? q.codes[rd_idx_i] : '0;
    assign count_o   = q.count;

    // -----------------------------------------------------------------
    // Checks
    // -----------------------------------------------------------------
    a_store_limit: assert property (@(posedge clk_i) disable iff (reset_i)
        q.count <= MAX_CODES) else $error("code store holds more than six");

    a_store_keep: assert property (@(posedge clk_i) disable iff (reset_i)
        ##1 (q.count >= $past(q.count) && (q.count == $past(q.count) ||
             q.codes[$past(q.count)] == $past(wr_code_i))))
        else $error("stored codes lost or overwritten");

    a_store_order: assert property (@(posedge clk_i) disable iff (reset_i)
        accept |=> (q.count == $past(q.count) + 3'h1) &&
                   (q.codes[$past(q.count)] == $past(wr_code_i)))
        else $error("accepted code not appended at the end");

endmodule : fcb_code_store

`default_nettype wire

// file: logic/fcb_reporter.sv
// Fault code reporter: code capture, lamp self-test and blink-code output
`timescale 1ns/1ps
`default_nettype none

// Function
// - Detected fault stores code, lamp lights
// - Held test button blinks out stored codes
// - Key on lights lamp 2-3 s
// - Lamp stays lit while codes stored
// - Each flash 0.4 s on, 0.4 s off
// - 1.2 s dark between the two digits
// - 2.4 s dark between codes
// - Each code shown three times running
// - Store holds six codes at most
// - After last code restart from first
// - Codes kept and shown in set order
// - Codes persist until power removal
// - Bad cam pattern while running sets 53
// - Coolant circuit high 33, low 43
// - Supervisor failure sets code 56
module fcb_reporter
    import fcb_pkg::*;
#(
    parameter logic [TMR_W-1:0] P_SELFTEST_CYC  = SELFTEST_CYC,
    parameter logic [TMR_W-1:0] P_FLASH_CYC     = FLASH_CYC,
    parameter logic [TMR_W-1:0] P_DIGIT_GAP_CYC = DIGIT_GAP_CYC,
    parameter logic [TMR_W-1:0] P_CODE_GAP_CYC  = CODE_GAP_CYC
)
(
    input  wire logic              clk_i,
    input  wire logic              reset_i,
    input  wire logic              ce_i,
    input  wire logic              key_on_i,
    input  wire logic              test_button_i,
    input  wire logic              engine_running_i,
    input  wire logic              fault_valid_i,
    input  wire logic [CODE_W-1:0] fault_code_i,
    input  wire logic              cam_position_signal_bad_i,
    input  wire logic              coolant_temp_sensor_high_i,
    input  wire logic              coolant_temp_sensor_low_i,
    input  wire logic              operating_check_supervisor_fail_i,
    output logic                   fault_indicator_lamp_o,
    output logic      [CNT_W-1:0]  trouble_code_count_o
);
    // -----------------------------------------------------------------
    // State
    // -----------------------------------------------------------------
    typedef struct packed {
        fcb_state_e          st;         // Reporter state
        logic [TMR_W-1:0]    timer;      // Cycles left in the current phase
        logic [CNT_W-1:0]    idx;        // Code being reported
        logic [1:0]          rep;        // Pass number of the current code
        logic                tens;       // Tens digit in progress
        logic [FLASH_W-1:0]  flashes;    // Flashes left in the digit
        logic [CODE_W-1:0]   code;       // Code latched for display
        logic [3:0]          pend;       // Named faults awaiting the store
        logic                key_q;      // Key level last cycle
        logic                lamp;       // Lamp drive
    } fcb_rep_s;

    fcb_rep_s           q;               // Registered state
    fcb_rep_s           n;               // Next state
    logic               key_rise;        // Key just turned on
    logic               reporting;       // In a blink-code state
    logic [3:0]         pend_set;        // Named faults seen this cycle
    logic [3:0]         pend_clr;        // Named fault handed to the store
    logic               wr;              // Store write strobe
    logic [CODE_W-1:0]  wr_code;         // Code to store
    logic [CODE_W-1:0]  rd_code;         // Store slot at q.idx
    logic [CNT_W-1:0]   count;           // Codes in store
    logic [CODE_W-1:0]  shown;           // Code to show next

    // Flash count of one digit; zero would be invisible so it shows ten
    function automatic logic [FLASH_W-1:0] digit_flashes(input logic [DIGIT_W-1:0] d);
        digit_flashes = (d == 4'h0) ? ZERO_FLASHES : d;
    endfunction : digit_flashes
    // Fixed code of each named fault source
    function automatic logic [CODE_W-1:0] named_code(input int unsigned i);
        case (i)
            0:       named_code = CODE_CAM_BAD;
            1:       named_code = CODE_COOL_HIGH;
            2:       named_code = CODE_COOL_LOW;
            default: named_code = CODE_SUPERVISOR;
        endcase
    endfunction : named_code
    // -----------------------------------------------------------------
    // Code store
    // -----------------------------------------------------------------
    fcb_code_store u_store (
        .clk_i     (clk_i),
        .reset_i   (reset_i),
        .ce_i      (ce_i),
        .wr_i      (wr),
        .wr_code_i (wr_code),
        .rd_idx_i  (q.idx),
        .rd_code_o (rd_code),
        .count_o   (count)
    );

    // -----------------------------------------------------------------
    // Next state
    // -----------------------------------------------------------------
    always_comb begin
        n         = q;
        wr        = 1'b0;
        wr_code   = '0;
        pend_clr  = 4'h0;
        key_rise  = key_on_i && !q.key_q;
        reporting = (q.st != ST_IDLE) && (q.st != ST_SELFTEST);
        shown     = (count == 3'h0) ? CODE_ALL_OK : rd_code;
        // Cam pattern only counts with the engine turning
        pend_set  = {operating_check_supervisor_fail_i, coolant_temp_sensor_low_i,
                     coolant_temp_sensor_high_i,
                     cam_position_signal_bad_i && engine_running_i};
        if (ce_i) begin
            n.key_q = key_on_i;
            // Generic fault has the port this cycle, named ones wait a turn
            if (fault_valid_i) begin
                wr      = 1'b1;
                wr_code = fault_code_i;
            end else begin
                for (int i = 3; i >= 0; i--) begin
                    if (q.pend[i]) begin
                        pend_clr = 4'h1 << i;
                        wr_code  = named_code(i);
                    end
                end
                wr = (q.pend != 4'h0);
            end
            // A new detection outranks the hand-over clear
            n.pend = (q.pend & ~pend_clr) | pend_set;
            if (key_rise) begin
                n.st    = ST_SELFTEST;
                n.timer = P_SELFTEST_CYC - 27'h1;
            end else if (reporting && !test_button_i) begin
                n.st = ST_IDLE;
            end else begin
                case (q.st)
                    // Start a report on the button
                    ST_IDLE: begin
                        if (test_button_i) begin
                            n.st  = ST_LOAD;
                            n.idx = 3'h0;
                            n.rep = 2'h0;
                        end
                    end
                    // Lamp held on while the timer runs
                    ST_SELFTEST: begin
                        if (q.timer == '0) begin
                            n.st = ST_IDLE;
                        end else begin
                            n.timer = q.timer - 27'h1;
                        end
                    end
                    // First code of a report, tens digit first
                    ST_LOAD: begin
                        n.code    = shown;
                        n.tens    = 1'b1;
                        n.flashes = digit_flashes(shown[7:4]);
                        n.st      = ST_FLASH_ON;
                        n.timer   = P_FLASH_CYC - 27'h1;
                    end
                    // Lit part of one flash
                    ST_FLASH_ON: begin
                        if (q.timer != '0) begin
                            n.timer = q.timer - 27'h1;
                        end else if (q.flashes > 4'h1) begin
                            n.st      = ST_FLASH_OFF;
                            n.timer   = P_FLASH_CYC - 27'h1;
                            n.flashes = q.flashes - 4'h1;
                        end else if (q.tens) begin
                            n.st    = ST_DIGIT_GAP;
                            n.timer = P_DIGIT_GAP_CYC - 27'h1;
                            n.tens  = 1'b0;
                        end else begin
                            n.st    = ST_CODE_GAP;
                            n.timer = P_CODE_GAP_CYC - 27'h1;
                            if (q.rep == REPEAT_LAST) begin
                                n.rep = 2'h0;
                                // Wrap to the oldest code after the newest
                                n.idx = (q.idx + 3'h1 >= count) ? 3'h0 : q.idx + 3'h1;
                            end else begin
                                n.rep = q.rep + 2'h1;
                            end
                        end
                    end
                    // Dark part of one flash
                    ST_FLASH_OFF: begin
                        if (q.timer == '0) begin
                            n.st    = ST_FLASH_ON;
                            n.timer = P_FLASH_CYC - 27'h1;
                        end else begin
                            n.timer = q.timer - 27'h1;
                        end
                    end
                    // Pause, then the units digit
                    ST_DIGIT_GAP: begin
                        if (q.timer == '0) begin
                            n.st      = ST_FLASH_ON;
                            n.timer   = P_FLASH_CYC - 27'h1;
                            n.flashes = digit_flashes(q.code[3:0]);
                        end else begin
                            n.timer = q.timer - 27'h1;
                        end
                    end
                    // Pause, then the next pass or next code in set order
                    ST_CODE_GAP: begin
                        if (q.timer == '0) begin
                            n.code    = shown;
                            n.tens    = 1'b1;
                            n.flashes = digit_flashes(shown[7:4]);
                            n.st      = ST_FLASH_ON;
                            n.timer   = P_FLASH_CYC - 27'h1;
                        end else begin
                            n.timer = q.timer - 27'h1;
                        end
                    end
                    default: begin
                        n.st = ST_IDLE;
                    end
                endcase
            end
            // Lamp follows the state it enters; store count lags one cycle
            n.lamp = (n.st == ST_FLASH_ON) || (n.st == ST_SELFTEST) ||
                     ((n.st == ST_IDLE) && (count != 3'h0));
        end
    end

    // -----------------------------------------------------------------
    // Registers
    // -----------------------------------------------------------------
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign fault_indicator_lamp_o = q.lamp;
    assign trouble_code_count_o   = count;
    // -----------------------------------------------------------------
    // Checks
    // -----------------------------------------------------------------
    logic [TMR_W-1:0] dwell_q;           // Enabled cycles spent in the state
    // Dwell counter for the checks; a fresh key edge restarts the self-test span
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            dwell_q <= '0;
        end else if (ce_i) begin
            dwell_q <= (n.st != q.st || key_rise) ? '0 : dwell_q + 27'h1;
        end
    end
    sequence s_leave(fcb_state_e s);
        ce_i && q.st == s && n.st != s && test_button_i && !key_rise;
    endsequence
    property p_dwell(fcb_state_e s, logic [TMR_W-1:0] cyc);
        @(posedge clk_i) disable iff (reset_i)
        s_leave(s) |-> (dwell_q + 27'h1 == cyc);
    endproperty
    a_flash_on_time: assert property (p_dwell(ST_FLASH_ON, P_FLASH_CYC))
        else $error("flash on time wrong");
    a_flash_off_time: assert property (p_dwell(ST_FLASH_OFF, P_FLASH_CYC))
        else $error("flash off time wrong");
    a_digit_gap_time: assert property (p_dwell(ST_DIGIT_GAP, P_DIGIT_GAP_CYC))
        else $error("digit gap time wrong");
    a_code_gap_time: assert property (p_dwell(ST_CODE_GAP, P_CODE_GAP_CYC))
        else $error("code gap time wrong");
    a_selftest_time: assert property (@(posedge clk_i) disable iff (reset_i)
        (ce_i && q.st == ST_SELFTEST && n.st == ST_IDLE) |->
        (dwell_q + 27'h1 == P_SELFTEST_CYC) && fault_indicator_lamp_o)
        else $error("self-test length or lamp wrong");
    a_lamp_codes: assert property (@(posedge clk_i) disable iff (reset_i)
        (q.st == ST_IDLE && $past(count) != 3'h0 && $past(ce_i)) |-> fault_indicator_lamp_o)
        else $error("lamp dark with codes stored");
    a_lamp_flash: assert property (@(posedge clk_i) disable iff (reset_i)
        (q.st inside {ST_FLASH_OFF, ST_DIGIT_GAP, ST_CODE_GAP}) |-> !fault_indicator_lamp_o)
        else $error("lamp lit in a dark phase");
    a_report_held: assert property (@(posedge clk_i) disable iff (reset_i)
        (ce_i && !test_button_i && reporting) |=> q.st inside {ST_IDLE, ST_SELFTEST})
        else $error("report continues after button release");
    a_repeat_bound: assert property (@(posedge clk_i) disable iff (reset_i)
        (ce_i && q.st == ST_FLASH_ON && n.st == ST_CODE_GAP && q.rep != REPEAT_LAST)
        |=> q.idx == $past(q.idx) && q.rep == $past(q.rep) + 2'h1)
        else $error("code left before its third pass");
    a_report_wrap: assert property (@(posedge clk_i) disable iff (reset_i)
        (s_leave(ST_FLASH_ON) ##0 (n.st == ST_CODE_GAP && q.rep == REPEAT_LAST &&
         q.idx + 3'h1 >= count)) |=> q.idx == 3'h0)
        else $error("report did not restart at the first code");
    a_cam_gate: assert property (@(posedge clk_i) disable iff (reset_i)
        (ce_i && !engine_running_i && !q.pend[0]) |=> !q.pend[0])
        else $error("cam fault taken with engine stopped");
endmodule : fcb_reporter

`default_nettype wire

// file: shared/fcb_pkg.sv
// Package with constants and types of the fault code blink reporter
package fcb_pkg;

    // -----------------------------------------------------------------
    // Clock and widths
    // -----------------------------------------------------------------
    localparam int unsigned CLK_HZ    = 50_000_000;      // System clock rate
    localparam int unsigned TMR_W     = 27;              // Fits the longest wait
    localparam int unsigned CODE_W    = 8;               // Two decimal digits, BCD
    localparam int unsigned DIGIT_W   = 4;               // One decimal digit
    localparam int unsigned CNT_W     = 3;               // Code count and index
    localparam int unsigned FLASH_W   = 4;               // Flashes left in a digit

    // -----------------------------------------------------------------
    // Store limits and report repeats
    // -----------------------------------------------------------------
    localparam logic [CNT_W-1:0] MAX_CODES    = 3'h6;    // Codes held at once
    localparam logic [1:0]       REPEAT_LAST  = 2'h2;    // Third pass of one code
    localparam logic [CNT_W-1:0] RESET_COUNT  = 3'h0;    // Store empty at power-up
    localparam logic [FLASH_W-1:0] ZERO_FLASHES = 4'ha;  // A zero digit shows ten

    // -----------------------------------------------------------------
    // Times in milliseconds and derived cycle counts
    // -----------------------------------------------------------------
    localparam int unsigned SELFTEST_MS  = 2500;         // Inside the 2 to 3 s span
    localparam int unsigned FLASH_MS     = 400;          // Lamp on, then lamp off
    localparam int unsigned DIGIT_GAP_MS = 1200;         // Dark between two digits
    localparam int unsigned CODE_GAP_MS  = 2400;         // Dark between two codes
    localparam int unsigned CYC_PER_MS   = CLK_HZ / 1000;
    localparam logic [TMR_W-1:0] SELFTEST_CYC  = TMR_W'(SELFTEST_MS * CYC_PER_MS);
    localparam logic [TMR_W-1:0] FLASH_CYC     = TMR_W'(FLASH_MS * CYC_PER_MS);
    localparam logic [TMR_W-1:0] DIGIT_GAP_CYC = TMR_W'(DIGIT_GAP_MS * CYC_PER_MS);
    localparam logic [TMR_W-1:0] CODE_GAP_CYC  = TMR_W'(CODE_GAP_MS * CYC_PER_MS);

    // -----------------------------------------------------------------
    // Trouble codes, BCD encoded
    // -----------------------------------------------------------------
    localparam logic [CODE_W-1:0] CODE_ALL_OK     = 8'h11;  // Shown when store empty
    localparam logic [CODE_W-1:0] CODE_COOL_HIGH  = 8'h33;  // Coolant signal high
    localparam logic [CODE_W-1:0] CODE_COOL_LOW   = 8'h43;  // Coolant signal low
    localparam logic [CODE_W-1:0] CODE_CAM_BAD    = 8'h53;  // Bad cam pattern
    localparam logic [CODE_W-1:0] CODE_SUPERVISOR = 8'h56;  // Supervisor failure

    // -----------------------------------------------------------------
    // Reporter states
    // -----------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SELFTEST,
        ST_LOAD,
        ST_FLASH_ON,
        ST_FLASH_OFF,
        ST_DIGIT_GAP,
        ST_CODE_GAP
    } fcb_state_e;

endpackage : fcb_pkg

// file: sim/fcb_lamp_button.sv
// Lamp watcher and test button model that decodes blink codes
`timescale 1ns/1ps
`default_nettype none

module fcb_lamp_button
    import fcb_pkg::*;
#(
    parameter int F  = 4,                       // Flash on/off cycles
    parameter int DG = 12,                      // Digit gap cycles
    parameter int CG = 24                       // Code gap cycles
)
(
    input  wire logic       clk_i,
    input  wire logic       lamp_i,
    input  wire logic       hold_i,
    output logic            test_button_o,
    output logic [7:0]      code_o = 8'h00,
    output logic            stb_o  = 1'b0,
    output logic [7:0]      err_o  = 8'h00
);
    // ---------------------------------------------------------------
    // Decoder state
    // ---------------------------------------------------------------
    logic       prev = 1'b0;                    // Lamp seen last cycle
    int         run  = 0;                       // Cycles at current level
    logic [3:0] cnt  = 4'h0;                    // Flashes in this digit
    logic [3:0] tens = 4'h0;                    // Finished first digit
    logic       sync = 1'b0;                    // Seen one code gap

    // Technician holds the button as long as asked
    assign test_button_o = hold_i;

    // Measure lamp runs; first code is skipped since its start merges with idle
    always @(posedge clk_i) begin
        stb_o <= 1'b0;
        run   <= run + 1;
        prev  <= lamp_i;
        if (!hold_i) begin
            sync <= 1'b0;
            cnt  <= 4'h0;
        end else if (lamp_i !== prev) begin
            run <= 1;
            if (!lamp_i) begin
                cnt <= cnt + 4'h1;
                if (sync && run != F) err_o <= err_o + 8'h01;
            end else if (run == DG) begin
                tens <= cnt;
                cnt  <= 4'h0;
            end else if (run == CG) begin
                if (sync) begin
                    code_o <= {tens, cnt};
                    stb_o  <= 1'b1;
                end
                sync <= 1'b1;
                cnt  <= 4'h0;
            end else if (sync && run != F) begin
                err_o <= err_o + 8'h01;
            end
        end
    end
endmodule : fcb_lamp_button
`default_nettype wire

// file: sim/tb_top.sv
// Self-checking bench of the fault code blink reporter
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_mismatch++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, a, b); end end

module tb_top;
    import fcb_pkg::*;
    logic clk_i = 1'b0, reset_i = 1'b1, key = 1'b0, run = 1'b0, fv = 1'b0, ce = 1'b1;
    logic cam = 1'b0, hi = 1'b0, lo = 1'b0, sup = 1'b0, hold = 1'b0, btn, lamp, stb;
    logic [7:0] fc = 8'h00, code, err;
    logic [2:0] count;
    int n_mismatch = 0, num_checks = 0, i, t;
    // Row: valid, cam, running, high, low, supervisor, code, expected count
    logic [16:0] rows [9] = '{{6'h20,8'h21,3'h1}, {6'h20,8'h21,3'h1}, {6'h10,8'h00,3'h1},
        {6'h18,8'h00,3'h2}, {6'h04,8'h00,3'h3}, {6'h02,8'h00,3'h4}, {6'h01,8'h00,3'h5},
        {6'h20,8'h12,3'h6}, {6'h20,8'h34,3'h6}};
    logic [7:0] exp_codes [18] = '{8'h21,8'h21,8'h53,8'h53,8'h53,8'h33,8'h33,8'h33,
        8'h43,8'h43,8'h43,8'h56,8'h56,8'h56,8'h12,8'h12,8'h12,8'h21};

    fcb_reporter #(.P_SELFTEST_CYC(27'h14), .P_FLASH_CYC(27'h4), .P_DIGIT_GAP_CYC(27'hc),
        .P_CODE_GAP_CYC(27'h18)) dut (.clk_i(clk_i), .reset_i(reset_i), .ce_i(ce),
        .key_on_i(key), .test_button_i(btn), .engine_running_i(run), .fault_valid_i(fv),
        .fault_code_i(fc), .cam_position_signal_bad_i(cam), .coolant_temp_sensor_high_i(hi),
        .coolant_temp_sensor_low_i(lo), .operating_check_supervisor_fail_i(sup),
        .fault_indicator_lamp_o(lamp), .trouble_code_count_o(count));
    // Model timing defaults equal the shortened phase lengths given above
    fcb_lamp_button lamp_model (.clk_i(clk_i), .lamp_i(lamp),
        .hold_i(hold), .test_button_o(btn), .code_o(code), .stb_o(stb), .err_o(err));

    // 50 MHz clock
    initial begin
        forever #10 clk_i = ~clk_i;
    end

    // Move a fixed delay past the rising edge
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #2;
    endtask : step

    task automatic end_of_test;
        $display("Checks %0d, mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : end_of_test

    initial begin
        step(6);
        reset_i = 1'b0;
        `CHK(lamp, 1'b0)
        `CHK(count, 3'h0)
        key = 1'b1;
        step(2);
        `CHK(lamp, 1'b1)
        // Enable low for ten cycles freezes the self-test, so the lit span stretches
        ce = 1'b0;
        step(10);
        ce = 1'b1;
        step(17);
        `CHK(lamp, 1'b1)
        step(4);
        `CHK(lamp, 1'b0)
        // Capture, refusal of duplicates, engine gating and a full store
        for (i = 0; i < 9; i++) begin
            {fv, cam, run, hi, lo, sup, fc} = rows[i][16:3];
            step(1);
            {fv, cam, hi, lo, sup} = 5'h00;
            step(4);
            run = 1'b0;
            `CHK(count, rows[i][2:0])
        end
        `CHK(lamp, 1'b1)
        // Hold the button and read codes back in set order, wrapping round
        hold = 1'b1;
        i = 0;
        for (t = 0; t < 4000 && i < 18; t++) begin
            step(1);
            if (stb === 1'b1) begin
                `CHK(code, exp_codes[i])
                i++;
            end
        end
        if (i < 18) n_mismatch++;
        `CHK(err, 8'h00)
        hold = 1'b0;
        step(3);
        `CHK(lamp, 1'b1)
        `CHK(count, 3'h6)
        reset_i = 1'b1;
        step(1);
        reset_i = 1'b0;
        step(2);
        `CHK(count, 3'h0)
        // Empty store still answers the button, with the all-clear code
        hold = 1'b1;
        for (t = 0; t < 400 && stb !== 1'b1; t++) step(1);
        `CHK(code, CODE_ALL_OK)
        hold = 1'b0;
        end_of_test();
    end
endmodule : tb_top
`default_nettype wire
